// ==== logic/i2c_master_sequencer.sv ====
// Master sequencer: START/STOP, address, data and pending commands.
module i2c_master_sequencer (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       link_clk,
	input  wire logic       start_cmd,
	input  wire logic       stop_cmd,
	input  wire logic       ack_cmd,
	input  wire logic       nack_cmd,
	input  wire logic       continue_cmd,
	input  wire logic       abort_cmd,
	input  wire logic       flush_queued_cmds,
	input  wire logic       auto_acknowledge,
	input  wire logic       transmit_buffer_write,
	input  wire logic [7:0] tx_wdata,
	input  wire logic       receive_buffer_read,
	output logic      [7:0] rx_rdata,
	output logic            rx_valid,
	output logic            tx_full,
	output logic      [7:0] sequencer_state_reg,
	output logic            bus_wait_flag,
	output logic            bus_busy,
	output logic            master_rx,
	output logic            stop_queued,
	output logic            start_queued,
	output logic            continue_queued,
	output logic            not_ack_queued,
	output logic            ack_queued,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n
);

	// ************************************************************
	// Declarations.
	// ************************************************************
	i2c_seq_pkg::seq_state_t state_q;   // Sequencer state.
	i2c_seq_pkg::action_t    act;       // Course taken this cycle.
	logic [1:0] phase_q;                // Quarter within a bit.
	logic [9:0] qcnt_q;                 // Cycles within a quarter.
	logic [3:0] bit_q;                  // Bit within a byte.
	logic [7:0] sh_q;                   // Shift register.
	logic       rd_q;                   // Master receiver role.
	logic       addr_q;                 // Next byte is an address.
	logic       nacked_q;               // Last byte was not acked.
	logic       nack_out_q;             // Acknowledge bit to send.
	logic       rs_q;                   // START is a repeated one.
	logic [4:0] pend_q;                 // Pending commands.
	logic [4:0] pend_set;               // Pending set strobes.
	logic [4:0] pend_clr;               // Pending consume/flush.
	logic       busy_q;                 // Bus owned by someone.
	logic [7:0] tx_data_q;              // Transmit buffer.
	logic       tx_full_q;              // Transmit buffer holds data.
	logic [7:0] rx_data_q;              // Receive buffer.
	logic       rx_full_q;              // Receive buffer holds data.
	logic       held_q;                 // Byte waiting for space.
	logic       wait_st;                // State may need software.
	logic       tick;                   // End of a quarter.
	logic       bit_end;                // End of a bit.
	logic       scl_low;                // Pull SCL this cycle.
	logic       sda_low;                // Pull SDA this cycle.
	logic [1:0] sda_m_q;                // SDA into the system clock.
	logic [2:0] st_m_q;                 // START toggle crossing.
	logic [2:0] sp_m_q;                 // STOP toggle crossing.
	logic       start_ev;               // Bus START seen.
	logic       stop_ev;                // Bus STOP seen.
	logic [1:0] lrst_q;                 // Reset into the link clock.
	logic [1:0] l_scl_q;                // SCL synchroniser.
	logic [1:0] l_sda_q;                // SDA synchroniser.
	logic       l_sda_p;                // Previous settled SDA.
	logic       l_st_t;                 // START event toggle.
	logic       l_sp_t;                 // STOP event toggle.

	// Maps a state and its context to the software visible code.
	function automatic logic [7:0] code_of(
		input i2c_seq_pkg::seq_state_t s, input logic nk);
		case (s)
			i2c_seq_pkg::S_IDLE:  code_of = i2c_seq_pkg::CODE_IDLE;
			i2c_seq_pkg::S_AWAIT: code_of = i2c_seq_pkg::CODE_ADDR;
			i2c_seq_pkg::S_TACK:  code_of = nk ?
				i2c_seq_pkg::CODE_TXNACK : i2c_seq_pkg::CODE_TXACK;
			i2c_seq_pkg::S_RACK:  code_of = i2c_seq_pkg::CODE_RXBYTE;
			i2c_seq_pkg::S_END:   code_of = i2c_seq_pkg::CODE_END;
			default:              code_of = i2c_seq_pkg::CODE_MOVE;
		endcase
	endfunction : code_of

	assign tick    = (qcnt_q == i2c_seq_pkg::QTR_CYC - 10'h001);
	assign bit_end = tick && (phase_q == 2'h3);
	assign wait_st = state_q inside {i2c_seq_pkg::S_IDLE,
		i2c_seq_pkg::S_AWAIT, i2c_seq_pkg::S_TACK,
		i2c_seq_pkg::S_RACK, i2c_seq_pkg::S_END};
	assign start_ev = st_m_q[1] ^ st_m_q[2];
	assign stop_ev  = sp_m_q[1] ^ sp_m_q[2];

	// ************************************************************
	// Link clock: bus condition detector.
	// ************************************************************
	// Reset is brought over first so the detector starts clean.
	always_ff @(posedge link_clk) begin
		lrst_q <= {lrst_q[0], rstn};
	end

	// Pins are settled by two flops; a START or STOP flips a toggle
	// because a one-cycle pulse would be lost in the slower domain.
	always_ff @(posedge link_clk) begin
		if (!lrst_q[1]) begin
			l_scl_q <= 2'h3;
			l_sda_q <= 2'h3;
			l_sda_p <= 1'b1;
			l_st_t  <= 1'b0;
			l_sp_t  <= 1'b0;
		end else begin
			l_scl_q <= {l_scl_q[0], scl_in};
			l_sda_q <= {l_sda_q[0], sda_in};
			l_sda_p <= l_sda_q[1];
			if (l_scl_q[1] && l_sda_p && !l_sda_q[1]) begin
				l_st_t <= ~l_st_t;
			end
			if (l_scl_q[1] && !l_sda_p && l_sda_q[1]) begin
				l_sp_t <= ~l_sp_t;
			end
		end
	end

	// ************************************************************
	// System clock: crossings and bus ownership.
	// ************************************************************
	// Toggles pass two flops; the third only feeds the edge compare.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_m_q  <= 3'h0;
			sp_m_q  <= 3'h0;
			sda_m_q <= 2'h3;
		end else begin
			st_m_q  <= {st_m_q[1:0], l_st_t};
			sp_m_q  <= {sp_m_q[1:0], l_sp_t};
			sda_m_q <= {sda_m_q[0], sda_in};
		end
	end

	// Busy from reset; a bus START wins over a same-cycle abort.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			busy_q <= i2c_seq_pkg::BUSY_RST;
		end else if (start_ev) begin
			busy_q <= 1'b1;
		end else if (stop_ev || abort_cmd) begin
			busy_q <= 1'b0;
		end
	end

	// ************************************************************
	// Decision: highest priority course whose inputs are ready.
	// ************************************************************
	always_comb begin
		act = i2c_seq_pkg::A_NONE;
		case (state_q)
			i2c_seq_pkg::S_IDLE: begin
				if (pend_q[i2c_seq_pkg::P_STRT] && !busy_q) begin
					act = i2c_seq_pkg::A_START;
				end
			end
			i2c_seq_pkg::S_AWAIT: begin
				if (pend_q[i2c_seq_pkg::P_STOP]) begin
					act = i2c_seq_pkg::A_STOP;
				end else if (tx_full_q) begin
					act = i2c_seq_pkg::A_SEND;
				end
			end
			i2c_seq_pkg::S_TACK: begin
				if (pend_q[i2c_seq_pkg::P_STOP]) begin
					act = i2c_seq_pkg::A_STOP;
				end else if (nacked_q && tx_full_q &&
					pend_q[i2c_seq_pkg::P_CONTINUE_CMD]) begin
					act = i2c_seq_pkg::A_SEND;
				end else if (pend_q[i2c_seq_pkg::P_STRT]) begin
					act = i2c_seq_pkg::A_START;
				end else if (!nacked_q && tx_full_q) begin
					act = i2c_seq_pkg::A_SEND;
				end
			end
			i2c_seq_pkg::S_RACK: begin
				// A stop needs a not-acknowledge on the bus first.
				if (pend_q[i2c_seq_pkg::P_STOP] ||
					pend_q[i2c_seq_pkg::P_NACK]) begin
					act = i2c_seq_pkg::A_NACK;
				end else if (pend_q[i2c_seq_pkg::P_ACK] &&
					!held_q && !rx_full_q) begin
					act = i2c_seq_pkg::A_ACK;
				end
			end
			i2c_seq_pkg::S_END: begin
				if (pend_q[i2c_seq_pkg::P_STOP]) begin
					act = i2c_seq_pkg::A_STOP;
				end else if (pend_q[i2c_seq_pkg::P_STRT]) begin
					act = i2c_seq_pkg::A_START;
				end
			end
			default: act = i2c_seq_pkg::A_NONE;
		endcase
	end

	// ************************************************************
	// Pending commands.
	// ************************************************************
	// Strobes set; consumption and flush clear; a set always wins.
	assign pend_set = {start_cmd, ack_cmd | auto_acknowledge,
		nack_cmd, continue_cmd, stop_cmd};
	assign pend_clr = {5{flush_queued_cmds}} | {
		act == i2c_seq_pkg::A_START,
		act == i2c_seq_pkg::A_ACK,
		act == i2c_seq_pkg::A_NACK,
		act == i2c_seq_pkg::A_SEND && state_q == i2c_seq_pkg::S_TACK
			&& nacked_q,
		act == i2c_seq_pkg::A_STOP};

	generate
		for (genvar i = 0; i < 5; i++) begin : g_pend
			always_ff @(posedge clock) begin
				if (!rstn) begin
					pend_q[i] <= 1'b0;
				end else begin
					pend_q[i] <= pend_set[i] |
						(pend_q[i] & ~pend_clr[i]);
				end
			end
		end
	endgenerate

	// ************************************************************
	// Buffers.
	// ************************************************************
	// A write to a full buffer is dropped and the old byte kept.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			tx_full_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else if (transmit_buffer_write && !tx_full_q) begin
			tx_full_q <= 1'b1;
			tx_data_q <= tx_wdata;
		end else if (act == i2c_seq_pkg::A_SEND) begin
			tx_full_q <= 1'b0;
		end
	end

	// A received byte waits in the shifter until the buffer frees.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rx_full_q <= 1'b0;
			rx_data_q <= 8'h00;
			held_q    <= 1'b0;
		end else begin
			if (bit_end && state_q == i2c_seq_pkg::S_RECV &&
				bit_q == i2c_seq_pkg::LAST_RX) begin
				held_q <= 1'b1;
			end else if (held_q && (!rx_full_q || receive_buffer_read)) begin
				held_q    <= 1'b0;
				rx_data_q <= sh_q;
			end
			if (held_q && (!rx_full_q || receive_buffer_read)) begin
				rx_full_q <= 1'b1;
			end else if (receive_buffer_read) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Sequencer and bit engine.
	// ************************************************************
	// Each bit is four quarters; SCL is low in the first two, except in a START bit.
	always_ff @(posedge clock) begin
		if (!rstn || abort_cmd) begin
			state_q    <= i2c_seq_pkg::S_IDLE;
			phase_q    <= 2'h0;
			qcnt_q     <= 10'h000;
			bit_q      <= 4'h0;
			sh_q       <= 8'h00;
			rd_q       <= 1'b0;
			addr_q     <= 1'b0;
			nacked_q   <= 1'b0;
			nack_out_q <= 1'b0;
			rs_q       <= 1'b0;
		end else if (wait_st) begin
			qcnt_q  <= 10'h000;
			phase_q <= 2'h0;
			case (act)
				i2c_seq_pkg::A_START: begin
					state_q <= i2c_seq_pkg::S_START;
					rs_q    <= (state_q != i2c_seq_pkg::S_IDLE);
					addr_q  <= 1'b1;
				end
				i2c_seq_pkg::A_STOP: state_q <= i2c_seq_pkg::S_STOP;
				i2c_seq_pkg::A_SEND: begin
					state_q <= i2c_seq_pkg::S_SHIFT;
					sh_q    <= tx_data_q;
					if (addr_q) begin
						rd_q <= tx_data_q[0];
					end
				end
				i2c_seq_pkg::A_ACK, i2c_seq_pkg::A_NACK: begin
					state_q    <= i2c_seq_pkg::S_ABIT;
					nack_out_q <= (act == i2c_seq_pkg::A_NACK);
				end
				default: state_q <= state_q;
			endcase
		end else begin
			qcnt_q <= tick ? 10'h000 : qcnt_q + 10'h001;
			if (tick) begin
				phase_q <= phase_q + 2'h1;
			end
			if (bit_end) begin
				bit_q <= bit_q + 4'h1;
				case (state_q)
					i2c_seq_pkg::S_START: begin
						state_q <= i2c_seq_pkg::S_AWAIT;
						bit_q   <= 4'h0;
					end
					i2c_seq_pkg::S_SHIFT: begin
						sh_q <= {sh_q[6:0], 1'b0};
						if (bit_q == i2c_seq_pkg::ACK_BIT) begin
							bit_q    <= 4'h0;
							nacked_q <= sda_m_q[1];
							addr_q   <= 1'b0;
							if (!(addr_q && rd_q)) begin
								state_q <= i2c_seq_pkg::S_TACK;
							end else if (sda_m_q[1]) begin
								state_q <= i2c_seq_pkg::S_END;
							end else begin
								state_q <= i2c_seq_pkg::S_RECV;
							end
						end
					end
					i2c_seq_pkg::S_RECV: begin
						sh_q <= {sh_q[6:0], sda_m_q[1]};
						if (bit_q == i2c_seq_pkg::LAST_RX) begin
							bit_q   <= 4'h0;
							state_q <= i2c_seq_pkg::S_RACK;
						end
					end
					i2c_seq_pkg::S_ABIT: begin
						bit_q   <= 4'h0;
						state_q <= nack_out_q ? i2c_seq_pkg::S_END
							: i2c_seq_pkg::S_RECV;
					end
					default: state_q <= i2c_seq_pkg::S_IDLE;
				endcase
			end
		end
	end

	// Line levels; a slave stretching SCL is not followed here.
	always_comb begin
		scl_low = !wait_st || state_q != i2c_seq_pkg::S_IDLE;
		sda_low = 1'b0;
		case (state_q)
			i2c_seq_pkg::S_START: begin
				scl_low = rs_q && phase_q == 2'h0;
				sda_low = phase_q[1];
			end
			i2c_seq_pkg::S_STOP: begin
				scl_low = !phase_q[1];
				sda_low = phase_q != 2'h3;
			end
			i2c_seq_pkg::S_SHIFT: begin
				scl_low = !phase_q[1];
				sda_low = bit_q != i2c_seq_pkg::ACK_BIT && !sh_q[7];
			end
			i2c_seq_pkg::S_RECV: scl_low = !phase_q[1];
			i2c_seq_pkg::S_ABIT: begin
				scl_low = !phase_q[1];
				sda_low = !nack_out_q;
			end
			i2c_seq_pkg::S_AWAIT: sda_low = 1'b1;
			default: sda_low = 1'b0;
		endcase
	end

	// ************************************************************
	// Registered outputs.
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rstn) begin
			scl_oe_n            <= 1'b1;
			sda_oe_n            <= 1'b1;
			bus_wait_flag       <= 1'b0;
			sequencer_state_reg <= i2c_seq_pkg::CODE_IDLE;
		end else begin
			scl_oe_n      <= !scl_low;
			sda_oe_n      <= !sda_low;
			bus_wait_flag <= wait_st && state_q != i2c_seq_pkg::S_IDLE
				&& act == i2c_seq_pkg::A_NONE;
			sequencer_state_reg <= code_of(state_q, nacked_q);
		end
	end

	assign scl_out         = 1'b0;
	assign sda_out         = 1'b0;
	assign rx_rdata        = rx_data_q;
	assign rx_valid        = rx_full_q;
	assign tx_full         = tx_full_q;
	assign bus_busy        = busy_q;
	assign master_rx       = rd_q;
	assign stop_queued     = pend_q[i2c_seq_pkg::P_STOP];
	assign continue_queued = pend_q[i2c_seq_pkg::P_CONTINUE_CMD];
	assign not_ack_queued  = pend_q[i2c_seq_pkg::P_NACK];
	assign ack_queued      = pend_q[i2c_seq_pkg::P_ACK];
	assign start_queued    = pend_q[i2c_seq_pkg::P_STRT];

	// ************************************************************
	// Assertions.
	// ************************************************************
	sequence seq_addr_wait;
		state_q == i2c_seq_pkg::S_AWAIT && !abort_cmd;
	endsequence

	sequence seq_bus_start;
		start_ev;
	endsequence

	AST_ADDR_CODE: assert property (@(posedge clock) disable iff (!rstn)
		seq_addr_wait ##1 (state_q == i2c_seq_pkg::S_AWAIT)
		|-> sequencer_state_reg == 8'h57)
		else $error("address wait not reported as 0x57");
	AST_NO_ADDR_STALL: assert property (@(posedge clock) disable iff (!rstn)
		seq_addr_wait and (tx_full_q && !stop_queued)
		|=> state_q == i2c_seq_pkg::S_SHIFT && !bus_wait_flag)
		else $error("stalled with address buffered");
	AST_HOLD_LOW: assert property (@(posedge clock) disable iff (!rstn)
		bus_wait_flag |-> !scl_oe_n)
		else $error("bus wait without SCL low");
	AST_WAIT_FREE: assert property (@(posedge clock) disable iff (!rstn)
		state_q == i2c_seq_pkg::S_IDLE && busy_q
		|=> state_q != i2c_seq_pkg::S_START)
		else $error("START issued on a busy bus");
	AST_BUSY_START: assert property (@(posedge clock) disable iff (!rstn)
		seq_bus_start |=> busy_q [*2])
		else $error("bus not busy after START");
	AST_FREE_STOP: assert property (@(posedge clock) disable iff (!rstn)
		stop_ev && !start_ev |=> !busy_q)
		else $error("bus not freed after STOP");
	AST_STOP_FIRST: assert property (@(posedge clock) disable iff (!rstn)
		state_q == i2c_seq_pkg::S_TACK && stop_queued && start_queued
		&& !abort_cmd && !flush_queued_cmds
		|=> state_q == i2c_seq_pkg::S_STOP && start_queued)
		else $error("stop not taken before start");
	AST_CONSUME: assert property (@(posedge clock) disable iff (!rstn)
		act == i2c_seq_pkg::A_START && !start_cmd |=> !start_queued)
		else $error("start still pending after use");
	AST_FLUSH: assert property (@(posedge clock) disable iff (!rstn)
		flush_queued_cmds && !stop_cmd && !start_cmd && !continue_cmd
		|=> !stop_queued && !start_queued && !continue_queued)
		else $error("flush left a command pending");
	AST_AUTO_ACK: assert property (@(posedge clock) disable iff (!rstn)
		auto_acknowledge [*2] |-> ack_queued)
		else $error("auto acknowledge not pending");
	AST_ABORT: assert property (@(posedge clock) disable iff (!rstn)
		abort_cmd && !start_ev |=> state_q == i2c_seq_pkg::S_IDLE
		&& !busy_q ##1 sequencer_state_reg == 8'h00)
		else $error("abort did not idle the bus");

endmodule : i2c_master_sequencer

// ==== pkg/i2c_seq_pkg.sv ====
// Constants, encodings and timing of the I2C master interaction sequencer.
package i2c_seq_pkg;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLK_NS = 5;       // System clock period in ns.
	localparam int QTR_NS = 2500;    // Quarter of an SCL bit in ns.
	// Least time, so the cycle count rounds up.
	localparam logic [9:0] QTR_CYC =
		10'((QTR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] ACK_BIT = 4'h8;  // Ninth bit of a byte.
	localparam logic [3:0] LAST_RX = 4'h7;  // Last received bit.
	localparam logic       BUSY_RST = 1'b1; // Bus unknown at reset.

	// ************************************************************
	// Pending command slots.
	// ************************************************************
	localparam int P_STOP = 0;
	localparam int P_CONTINUE_CMD = 1;
	localparam int P_NACK = 2;
	localparam int P_ACK  = 3;
	localparam int P_STRT = 4;

	// ************************************************************
	// Software visible state codes.
	// ************************************************************
	localparam logic [7:0] CODE_IDLE   = 8'h00;
	localparam logic [7:0] CODE_MOVE   = 8'h01;
	localparam logic [7:0] CODE_ADDR   = 8'h57;
	localparam logic [7:0] CODE_TXACK  = 8'h97;
	localparam logic [7:0] CODE_TXNACK = 8'h9f;
	localparam logic [7:0] CODE_RXBYTE = 8'hb3;
	localparam logic [7:0] CODE_END    = 8'hd7;

	// Sequencer states, one-hot.
	typedef enum logic [9:0] {
		S_IDLE  = 10'h001,
		S_START = 10'h002,
		S_AWAIT = 10'h004,
		S_SHIFT = 10'h008,
		S_TACK  = 10'h010,
		S_RECV  = 10'h020,
		S_RACK  = 10'h040,
		S_ABIT  = 10'h080,
		S_END   = 10'h100,
		S_STOP  = 10'h200
	} seq_state_t;

	// Course chosen at a decision point, one-hot.
	typedef enum logic [5:0] {
		A_NONE  = 6'h01,
		A_STOP  = 6'h02,
		A_START = 6'h04,
		A_SEND  = 6'h08,
		A_ACK   = 6'h10,
		A_NACK  = 6'h20
	} action_t;

endpackage : i2c_seq_pkg

// ==== verif/i2c_slave_model.sv ====
// Bus slave model: acknowledges the address and returns a fixed byte.
module i2c_slave_model #(
	parameter logic [7:0] RD_BYTE = 8'h5a  // Byte returned on reads.
) (
	input  wire logic scl,      // Bus clock level.
	input  wire logic sda,      // Bus data level.
	output logic      sda_oe_n  // Low pulls the data line low.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;  // Address byte shifted in, MSB first.
	logic       nack; // Master refused the byte just read.

	// ************************************************************
	// Frame engine.
	// ************************************************************
	// A frame opens on START; a STOP kills it and frees the line.
	initial begin
		sda_oe_n = 1'b1;
		forever begin
			@(negedge sda iff scl === 1'b1);
			fork : frame
				begin
					repeat (8) @(posedge scl) sh = {sh[6:0], sda};
					@(negedge scl) sda_oe_n = 1'b0;
					// Data changes only while the clock is low; a master
					// NACK ends a read so the line is free for its STOP.
					nack = 1'b0;
					while (!nack) begin
						for (int i = 7; i >= 0; i--) begin
							@(negedge scl) sda_oe_n = sh[0] ? RD_BYTE[i] : 1'b1;
						end
						@(negedge scl) sda_oe_n = 1'b1;
						@(posedge scl) nack = sh[0] & sda;
					end
				end
				begin
					@(posedge sda iff scl === 1'b1);
				end
			join_any
			disable frame;
			sda_oe_n = 1'b1;
		end
	end
endmodule : i2c_slave_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the master interaction sequencer.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock, rstn, link_clk; // Clocks and reset.
	logic [6:0] cmd;      // Strobes: flush,abort,continue_cmd,nack,ack,stop,start.
	logic       auto_ack; // Automatic acknowledge level.
	logic       tx_wr;    // Transmit buffer write strobe.
	logic [7:0] tx_d;     // Byte written.
	logic       rx_rd;    // Receive buffer pop strobe.
	logic [7:0] rx_d, st; // Received byte and state code.
	logic       rx_v, tx_f, hold, busy, mrx;
	logic [4:0] q;        // Queued: stop,start,continue_cmd,nack,ack.
	logic       scl_oe_n, sda_oe_n, sl_oe_n;
	wire        scl = scl_oe_n;            // Only the master drives it.
	wire        sda = sda_oe_n & sl_oe_n;  // Pulled up, any party pulls.
	int         n_fail, tests_run, stall57;

	i2c_master_sequencer DUT (.clock(clock), .rstn(rstn),
		.link_clk(link_clk), .start_cmd(cmd[0]), .stop_cmd(cmd[1]),
		.ack_cmd(cmd[2]), .nack_cmd(cmd[3]), .continue_cmd(cmd[4]),
		.abort_cmd(cmd[5]), .flush_queued_cmds(cmd[6]),
		.auto_acknowledge(auto_ack), .transmit_buffer_write(tx_wr),
		.tx_wdata(tx_d), .receive_buffer_read(rx_rd), .rx_rdata(rx_d),
		.rx_valid(rx_v), .tx_full(tx_f), .sequencer_state_reg(st),
		.bus_wait_flag(hold), .bus_busy(busy), .master_rx(mrx),
		.stop_queued(q[4]), .start_queued(q[3]), .continue_queued(q[2]),
		.not_ack_queued(q[1]), .ack_queued(q[0]), .scl_in(scl),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
		.sda_oe_n(sda_oe_n));

	i2c_slave_model SLV (.scl(scl), .sda(sda), .sda_oe_n(sl_oe_n));

	// ************************************************************
	// Clocks, monitor and watchdog.
	// ************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Link clock is offset so its edges never line up with the core.
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	// Counts cycles spent waiting for an address.
	always @(negedge clock) begin
		if (hold === 1'b1 && st === 8'h57) stall57++;
	end
	initial begin
		#450000;
		n_fail++;
		complete_run;
	end

	// ************************************************************
	// Shared tasks.
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic strobe(input logic [6:0] m);
		@(negedge clock) cmd = m;
		@(negedge clock) cmd = 7'h00;
	endtask : strobe

	task automatic write_tx(input logic [7:0] b);
		@(negedge clock) begin
			tx_wr = 1'b1;
			tx_d = b;
		end
		@(negedge clock) tx_wr = 1'b0;
	endtask : write_tx

	// Bounded wait for a state code, then compares it.
	task automatic wait_st(input logic [7:0] code, input int lim);
		int k = 0;
		while (st !== code && k < lim) begin
			@(negedge clock);
			k++;
		end
		chk("state", code, st);
	endtask : wait_st

	task automatic complete_run;
		if (n_fail == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic t_queue;
		chk("state", 8'h00, st);
		chk("busy", 8'h01, {7'h00, busy});
		strobe(7'h1e);
		chk("queued", 8'h17, {3'h0, q});
		strobe(7'h40);
		chk("queued", 8'h00, {3'h0, q});
		auto_ack = 1'b1;
		strobe(7'h40);
		chk("queued", 8'h01, {3'h0, q});
		auto_ack = 1'b0;
		strobe(7'h40);
		chk("queued", 8'h00, {3'h0, q});
		// Bus still busy from reset, so the START must only queue.
		strobe(7'h01);
		repeat (100) @(negedge clock);
		chk("queued", 8'h08, {3'h0, q});
		chk("sda_oe_n", 8'h01, {7'h00, sda_oe_n});
	endtask : t_queue

	task automatic t_write;
		strobe(7'h20);
		repeat (10) @(negedge clock);
		chk("queued", 8'h00, {3'h0, q});
		// SDA falls only in the second half of the START bit.
		repeat (1000) @(negedge clock);
		chk("sda_oe_n", 8'h00, {7'h00, sda_oe_n});
		wait_st(8'h57, 3000);
		repeat (300) @(negedge clock);
		chk("wait", 8'h01, {7'h00, hold});
		chk("scl_oe_n", 8'h00, {7'h00, scl_oe_n});
		chk("state", 8'h57, st);
		write_tx(8'ha0);
		wait_st(8'h97, 20000);
		repeat (2) @(negedge clock);
		chk("wait", 8'h01, {7'h00, hold});
		chk("master_rx", 8'h00, {7'h00, mrx});
		// STOP and START together: STOP first, then a new START.
		strobe(7'h03);
		wait_st(8'h57, 5000);
		chk("queued", 8'h00, {3'h0, q});
		strobe(7'h02);
		wait_st(8'h00, 3000);
		repeat (40) @(negedge clock);
		chk("queued", 8'h00, {3'h0, q});
		chk("lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
		chk("busy", 8'h00, {7'h00, busy});
	endtask : t_write

	// Address is buffered before START, so no stall is allowed.
	task automatic t_read;
		stall57 = 0;
		write_tx(8'ha1);
		chk("tx_full", 8'h01, {7'h00, tx_f});
		strobe(7'h01);
		wait_st(8'hb3, 40000);
		repeat (2) @(negedge clock);
		chk("stalls", 8'h00, stall57[7:0]);
		chk("wait", 8'h01, {7'h00, hold});
		chk("master_rx", 8'h01, {7'h00, mrx});
		chk("rx_valid", 8'h01, {7'h00, rx_v});
		chk("rx_rdata", 8'h5a, rx_d);
		strobe(7'h02);
		wait_st(8'h00, 8000);
		repeat (40) @(negedge clock);
		chk("lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
		@(negedge clock) rx_rd = 1'b1;
		@(negedge clock) rx_rd = 1'b0;
		chk("rx_valid", 8'h00, {7'h00, rx_v});
	endtask : t_read

	initial begin
		cmd = 7'h00;
		auto_ack = 1'b0;
		tx_wr = 1'b0;
		tx_d = 8'h00;
		rx_rd = 1'b0;
		rstn = 1'b0;
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		t_queue;
		t_write;
		t_read;
		complete_run;
	end
endmodule : tb_top
